/* rtl/spi_status_buffer_irq_regs.sv */
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spi_regs_consts.svh"
module spi_status_buffer_irq_regs
  import spi_regs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [`AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [`AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Shift engine status
  input wire logic eng_tx_taken,
  input wire logic eng_rx_done,
  input wire logic [7:0] eng_rx_char,
  input wire logic eng_busy,
  input wire logic eng_conflict,
  input wire logic eng_tx_bit,
  // Shift engine control
  output logic eng_rst_hold,
  output logic eng_char7,
  output logic eng_master,
  output logic eng_four_wire,
  output logic [7:0] tx_char,
  output logic tx_pending,
  output logic rx_serial,
  // Receive data pin
  input wire logic somi_pin,
  // Interrupts
  output logic rx_irq,
  output logic tx_irq,
  output logic irq
);
  regs_state_t s;
  regs_state_t n;
  sel_t wsel;
  sel_t rsel;
  logic wr_fire;
  logic rd_rx;
  logic [`EV_W-1:0] ev_set;
  logic ev_clr_we;
  logic ev_msk_we;
  logic [`EV_W-1:0] ev_status;
  logic [`EV_W-1:0] ev_mask;
  logic [15:0] rd_word;

  localparam regs_state_t RESET_STATE = '{
    soft_rst: 1'b1,
    tx_empty: 1'b1,
    default: '0
  };

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Map a byte address to a register
  function automatic sel_t decode(input logic [`AXI_AW-1:0] a);
    decode = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[`AXI_AW-1:2])
        `IDX_STATUS: decode = SEL_STATUS;
        `IDX_RXBUF: decode = SEL_RXBUF;
        `IDX_TXBUF: decode = SEL_TXBUF;
        `IDX_IE: decode = SEL_IE;
        `IDX_IFG: decode = SEL_IFG;
        `IDX_CTRL: decode = SEL_CTRL;
        `IDX_EVST: decode = SEL_EVST;
        `IDX_EVMSK: decode = SEL_EVMSK;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // Force the MSB low for 7-bit characters
  function automatic logic [7:0] justify(input logic [7:0] c,
                                         input logic seven);
    justify = c;
    if (seven) begin
      justify[`CHAR_MSB] = 1'b0;
    end
  endfunction

  // ----------------------------------------
  // Read data mux, reserved bits zero
  // ----------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    case (rsel)
      SEL_STATUS: begin
        rd_word[`ST_LISTEN] = s.listen;
        rd_word[`ST_CONFLICT] = s.fe;
        rd_word[`ST_OVERRUN] = s.oe;
        rd_word[`ST_BUSY] = s.busy;
      end
      SEL_RXBUF: rd_word[7:0] = s.rx_data;
      SEL_TXBUF: rd_word[7:0] = s.tx_data;
      SEL_IE: begin
        rd_word[`FL_TX] = s.tx_ie;
        rd_word[`FL_RX] = s.rx_ie;
      end
      SEL_IFG: begin
        rd_word[`FL_TX] = s.tx_empty;
        rd_word[`FL_RX] = s.rx_full;
      end
      SEL_CTRL: begin
        rd_word[`CT_SWRST] = s.soft_rst;
        rd_word[`CT_CHAR7] = s.char7;
        rd_word[`CT_MASTER] = s.master;
        rd_word[`CT_4WIRE] = s.four_wire;
      end
      SEL_EVST: rd_word[`EV_W-1:0] = ev_status;
      SEL_EVMSK: rd_word[`EV_W-1:0] = ev_mask;
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    wr_fire = 1'b0;
    rd_rx = 1'b0;
    ev_set = '0;
    ev_clr_we = 1'b0;
    ev_msk_we = 1'b0;
    wsel = decode(s.awaddr);
    rsel = decode(araddr);
    // Address and data captured in either order
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wbyte = wdata[7:0];
      n.wlane = wstrb[0];
    end
    // Write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wr_fire = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // Register effects of a write; only the low lane carries fields
    if (wr_fire && s.wlane) begin
      case (wsel)
        SEL_STATUS: begin
          if (s.soft_rst) begin
            n.listen = s.wbyte[`ST_LISTEN];
            n.fe = s.wbyte[`ST_CONFLICT];
            n.oe = s.wbyte[`ST_OVERRUN];
          end
        end
        SEL_TXBUF: begin
          n.tx_data = justify(s.wbyte, s.char7);
          n.tx_empty = 1'b0;
        end
        SEL_IE: begin
          n.tx_ie = s.wbyte[`FL_TX];
          n.rx_ie = s.wbyte[`FL_RX];
        end
        SEL_IFG: begin
          n.tx_empty = s.wbyte[`FL_TX];
          n.rx_full = s.wbyte[`FL_RX];
        end
        SEL_CTRL: begin
          n.soft_rst = s.wbyte[`CT_SWRST];
          if (s.soft_rst) begin
            n.char7 = s.wbyte[`CT_CHAR7];
            n.master = s.wbyte[`CT_MASTER];
            n.four_wire = s.wbyte[`CT_4WIRE];
          end
        end
        SEL_EVST: ev_clr_we = 1'b1;
        SEL_EVMSK: ev_msk_we = 1'b1;
        default: n.bresp = s.bresp == `RESP_OKAY ? n.bresp : n.bresp;
      endcase
    end
    // Read answer one cycle after the address
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      rd_rx = (rsel == SEL_RXBUF);
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    // Receive read clears errors and the receive flag
    if (rd_rx) begin
      n.oe = 1'b0;
      n.fe = 1'b0;
      n.rx_full = 1'b0;
    end
    // Serial logic held while soft reset is set
    if (s.soft_rst) begin
      n.rx_full = 1'b0;
      n.tx_empty = 1'b1;
    end
    n.busy = eng_busy && !s.soft_rst;
    // Hardware events, applied last so they win over clears
    if (!s.soft_rst) begin
      if (eng_tx_taken) begin
        n.tx_empty = 1'b1;
        ev_set[`EV_TX] = 1'b1;
      end
      if (eng_rx_done) begin
        if (s.rx_full && !rd_rx) begin
          n.oe = 1'b1;
          ev_set[`EV_OVR] = 1'b1;
        end
        n.rx_data = justify(eng_rx_char, s.char7);
        n.rx_full = 1'b1;
        ev_set[`EV_RX] = 1'b1;
      end
      if (eng_conflict && s.master && s.four_wire) begin
        n.fe = 1'b1;
        ev_set[`EV_CONF] = 1'b1;
      end
    end
    // Pin synchroniser and loopback select
    n.somi_s1 = somi_pin;
    n.somi_s2 = s.somi_s1;
    n.rx_serial = s.listen ? eng_tx_bit : s.somi_s2;
    // Per-direction requests
    n.rx_irq = n.rx_full && n.rx_ie;
    n.tx_irq = n.tx_empty && n.tx_ie;
    // Ready flags for the next cycle
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= RESET_STATE;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------
  event_irq_unit u_events (
    .ref_clk(ref_clk),
    .rst(rst),
    .ev_set(ev_set),
    .clr_we(ev_clr_we),
    .msk_we(ev_msk_we),
    .wr_bits(s.wbyte[`EV_W-1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(irq)
  );

  // Outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {16'h0000, s.rdata};
  assign eng_rst_hold = s.soft_rst;
  assign eng_char7 = s.char7;
  assign eng_master = s.master;
  assign eng_four_wire = s.four_wire;
  assign tx_char = s.tx_data;
  assign tx_pending = !s.tx_empty;
  assign rx_serial = s.rx_serial;
  assign rx_irq = s.rx_irq;
  assign tx_irq = s.tx_irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_loopback;
    s.listen |=> (s.rx_serial == $past(eng_tx_bit));
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback does not carry transmitter bit");

  property p_conflict_set;
    (eng_conflict && s.master && s.four_wire && !s.soft_rst) |=> s.fe;
  endproperty
  a_conflict_set: assert property (p_conflict_set)
    else $error("conflict flag not set in 4-wire master");

  property p_conflict_cause;
    $rose(s.fe) |-> $past(eng_conflict && s.master && s.four_wire
                          || wr_fire && wsel == SEL_STATUS && s.soft_rst);
  endproperty
  a_conflict_cause: assert property (p_conflict_cause)
    else $error("conflict flag set without a 4-wire master conflict");

  property p_overrun;
    (eng_rx_done && s.rx_full && !rd_rx && !s.soft_rst) |=> s.oe;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_rx_read_clears;
    (rd_rx && !eng_rx_done && !eng_conflict && !wr_fire) |=> (!s.oe && !s.fe && !s.rx_full);
  endproperty
  a_rx_read_clears: assert property (p_rx_read_clears)
    else $error("receive read did not clear flags");

  property p_busy;
    (eng_busy && !s.soft_rst) ##1 1'b1 |-> s.busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("activity bit missed a transfer");

  property p_status_locked;
    !s.soft_rst |=> $stable(s.listen);
  endproperty
  a_status_locked: assert property (p_status_locked)
    else $error("status field changed outside soft reset");

  property p_rx_seven;
    (eng_rx_done && s.char7 && !s.soft_rst) |=> !s.rx_data[`CHAR_MSB];
  endproperty
  a_rx_seven: assert property (p_rx_seven)
    else $error("7-bit receive MSB not zero");

  property p_tx_hold;
    !(wr_fire && wsel == SEL_TXBUF) |=> $stable(s.tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit holding changed without a write");

  property p_tx_write;
    (wr_fire && s.wlane && wsel == SEL_TXBUF && !eng_tx_taken && !s.soft_rst)
      |=> (!s.tx_empty && !tx_pending == s.tx_empty);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("transmit write did not clear transmit flag");

  property p_tx_taken;
    (eng_tx_taken && !s.soft_rst) |=> ##[0:1] s.tx_empty;
  endproperty
  a_tx_taken: assert property (p_tx_taken)
    else $error("transmit flag not set when holding emptied");

  property p_rx_done;
    (eng_rx_done && !s.soft_rst) |=> s.rx_full;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("receive flag not set on character");

  property p_hold;
    s.soft_rst |=> (!s.busy && s.tx_empty);
  endproperty
  a_hold: assert property (p_hold)
    else $error("serial logic not held in soft reset");

  property p_tx_seven;
    (wr_fire && s.wlane && wsel == SEL_TXBUF && s.char7) |=> !s.tx_data[`CHAR_MSB];
  endproperty
  a_tx_seven: assert property (p_tx_seven)
    else $error("7-bit transmit MSB not zero");
  property p_irq_gate;
    (s.rx_irq == (s.rx_full && s.rx_ie)) && (s.tx_irq == (s.tx_empty && s.tx_ie));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request without flag and enable");

  property p_reserved;
    s.rvalid |-> (rdata[31:16] == 16'h0000 && (s.rresp == `RESP_OKAY || s.rdata == 16'h0000));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved read bits not zero");

  c_overrun: cover property (eng_rx_done && s.rx_full && !rd_rx && !s.soft_rst);
  c_loopback: cover property (s.listen && !s.soft_rst && eng_busy);
  c_tx_write: cover property (wr_fire && wsel == SEL_TXBUF);
  c_irq: cover property (irq && s.rx_irq);
endmodule
`default_nettype wire

/* common/spi_regs_consts.svh */
`ifndef SPI_REGS_CONSTS_SVH
`define SPI_REGS_CONSTS_SVH
// Register indices, byte address is the index times four
`define IDX_STATUS 8'h08
`define IDX_RXBUF 8'h0c
`define IDX_TXBUF 8'h0e
`define IDX_IE 8'h2a
`define IDX_IFG 8'h2c
`define IDX_CTRL 8'h30
`define IDX_EVST 8'h31
`define IDX_EVMSK 8'h32
`define AXI_AW 10
// Serial status fields
`define ST_LISTEN 7
`define ST_CONFLICT 6
`define ST_OVERRUN 5
`define ST_BUSY 0
// Enable and flag fields, same layout
`define FL_TX 1
`define FL_RX 0
// Control fields
`define CT_SWRST 0
`define CT_CHAR7 1
`define CT_MASTER 2
`define CT_4WIRE 3
// Event status and mask fields
`define EV_RX 0
`define EV_TX 1
`define EV_OVR 2
`define EV_CONF 3
`define EV_W 4
// Character and bus answers
`define CHAR_MSB 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* common/spi_regs_pkg.sv */
`default_nettype none
`include "spi_regs_consts.svh"
package spi_regs_pkg;
  // Register selected by an address
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_STATUS = 4'b0001,
    SEL_RXBUF = 4'b0010,
    SEL_TXBUF = 4'b0011,
    SEL_IE = 4'b0100,
    SEL_IFG = 4'b0101,
    SEL_CTRL = 4'b0110,
    SEL_EVST = 4'b0111,
    SEL_EVMSK = 4'b1000
  } sel_t;
  // Whole state of the register bank except the event status, mask and irq
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [`AXI_AW-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic listen;
    logic fe;
    logic oe;
    logic busy;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic tx_empty;
    logic rx_full;
    logic tx_ie;
    logic rx_ie;
    logic soft_rst;
    logic char7;
    logic master;
    logic four_wire;
    logic tx_irq;
    logic rx_irq;
    logic somi_s1;
    logic somi_s2;
    logic rx_serial;
  } regs_state_t;
  // State of the event interrupt unit
  typedef struct packed {
    logic [`EV_W-1:0] status;
    logic [`EV_W-1:0] mask;
    logic irq;
  } ev_state_t;
endpackage
`default_nettype wire

/* rtl/event_irq_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_regs_consts.svh"
module event_irq_unit
  import spi_regs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Event pulses and software access
  input wire logic [`EV_W-1:0] ev_set,
  input wire logic clr_we,
  input wire logic msk_we,
  input wire logic [`EV_W-1:0] wr_bits,
  // State and interrupt
  output logic [`EV_W-1:0] status,
  output logic [`EV_W-1:0] mask,
  output logic irq
);
  ev_state_t s;
  ev_state_t n;

  // ----------------------------------------
  // Sticky status, mask and level interrupt
  // ----------------------------------------
  // Write one clears, an event in the same cycle wins
  always_comb begin
    n = s;
    if (clr_we) begin
      n.status = s.status & ~wr_bits;
    end
    n.status = n.status | ev_set;
    if (msk_we) begin
      n.mask = wr_bits;
    end
    n.irq = |(n.status & n.mask);
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign status = s.status;
  assign mask = s.mask;
  assign irq = s.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_irq_level;
    irq == |(status & mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not follow masked status");

  property p_set_wins;
    |ev_set |=> ((status & $past(ev_set)) == $past(ev_set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a clear");
endmodule
`default_nettype wire

/* test/spi_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Shift engine stand-in
// ------------------------------
module spi_engine_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bank side
  input wire logic eng_rst_hold,
  input wire logic [7:0] tx_char,
  input wire logic tx_pending,
  // Bench commands
  input wire logic rx_req,
  input wire logic [7:0] rx_val,
  input wire logic conf_req,
  input wire logic [3:0] tx_wait,
  // Engine outputs
  output logic eng_tx_taken,
  output logic eng_rx_done,
  output logic [7:0] eng_rx_char,
  output logic eng_conflict,
  output logic eng_tx_bit,
  output logic eng_busy,
  output logic [7:0] sent_char
);
  logic [3:0] wait_reg;
  logic [3:0] shift_reg;
  // Take the held character after tx_wait idle cycles, then shift it out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 4'h0;
      shift_reg <= 4'h0;
      eng_tx_taken <= 1'b0;
      eng_rx_done <= 1'b0;
      eng_rx_char <= 8'h00;
      eng_conflict <= 1'b0;
      eng_tx_bit <= 1'b0;
      sent_char <= 8'h00;
    end else begin
      eng_tx_taken <= 1'b0;
      eng_rx_done <= rx_req;
      eng_rx_char <= rx_req ? rx_val : ~eng_rx_char; // Garbage between characters
      eng_conflict <= conf_req;
      eng_tx_bit <= (shift_reg != 4'h0) ? sent_char[shift_reg[2:0] - 3'h1] : ~eng_tx_bit;
      if (shift_reg != 4'h0) shift_reg <= shift_reg - 4'h1;
      if (eng_rst_hold) begin
        wait_reg <= 4'h0;
        shift_reg <= 4'h0;
      end else if (tx_pending && shift_reg == 4'h0 && !eng_tx_taken) begin
        if (wait_reg == tx_wait) begin
          eng_tx_taken <= 1'b1;
          sent_char <= tx_char;
          shift_reg <= 4'h8;
          wait_reg <= 4'h0;
        end else wait_reg <= wait_reg + 4'h1;
      end
    end
  end
  // Busy while bits remain in the shifter
  assign eng_busy = shift_reg != 4'h0;
endmodule
`default_nettype wire

/* test/spi_status_buffer_irq_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_regs_consts.svh"
module spi_status_buffer_irq_regs_tb_top import spi_regs_pkg::*;;
  // ------------------------------
  // Signals
  // ------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [`AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd, rv, cf;
  logic [3:0] wstrb = 4'hf, tx_wait = 4'h0;
  logic somi_pin = 1'b0, rx_req = 1'b0, conf_req = 1'b0;
  logic [7:0] rx_val = 8'h00, c, d, tx_char, eng_rx_char, sent_char;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, eng_tx_taken, eng_rx_done, eng_busy;
  logic eng_conflict, eng_tx_bit, eng_rst_hold, eng_char7, eng_master, eng_four_wire;
  logic tx_pending, rx_serial, rx_irq, tx_irq, irq, b;
  int num_errors = 0, n_tests = 0, seed = 17;

  // Clock and units
  always #10 ref_clk = ~ref_clk;
  spi_status_buffer_irq_regs dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .eng_tx_taken, .eng_rx_done, .eng_rx_char,
    .eng_busy, .eng_conflict, .eng_tx_bit, .eng_rst_hold, .eng_char7, .eng_master,
    .eng_four_wire, .tx_char, .tx_pending, .rx_serial, .somi_pin, .rx_irq, .tx_irq, .irq);
  spi_engine_model eng (.ref_clk, .rst, .eng_rst_hold, .tx_char, .tx_pending, .rx_req,
    .rx_val, .conf_req, .tx_wait, .eng_tx_taken, .eng_rx_done, .eng_rx_char,
    .eng_conflict, .eng_tx_bit, .eng_busy, .sent_char);

  // ------------------------------
  // Tasks
  // ------------------------------
  // Expected character after the length setting
  function automatic logic [31:0] rxe(input logic [7:0] v, input logic s7);
    return {24'h0, s7 ? {1'b0, v[6:0]} : v};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdr(input logic [7:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
    rdr(idx);
    chk(rd, e);
  endtask
  // Engine event pulse, then let flags settle
  task automatic ev(input logic r, input logic f, input logic [7:0] v);
    rx_req <= r;
    conf_req <= f;
    rx_val <= v;
    @(posedge ref_clk);
    rx_req <= 1'b0;
    conf_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rchk(`IDX_STATUS, 32'h0);
    rchk(`IDX_RXBUF, 32'h0);
    rchk(`IDX_IE, 32'h0);
    rchk(`IDX_IFG, 32'h2);
    chk(eng_rst_hold, 1'b1);
    rchk(8'h01, 32'h0);
    chk(rsp, `RESP_SLVERR);
    wr(8'h01, 32'hffffffff);
    chk(rsp, `RESP_SLVERR);
    ev(1'b1, 1'b0, 8'h5a);
    rchk(`IDX_IFG, 32'h2);
    wr(`IDX_STATUS, 32'hffffffdf);
    rchk(`IDX_STATUS, 32'hc0);
    wr(`IDX_STATUS, 32'h80);
    wr(`IDX_EVMSK, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(`IDX_CTRL, 32'hd | (s << 1));
      wr(`IDX_CTRL, 32'hc | (s << 1));
      wr(`IDX_IE, 32'h3);
      chk(eng_rst_hold, 1'b0);
      chk(eng_char7, s[0]);
      wr(`IDX_STATUS, 32'h20);
      chk(rsp, `RESP_OKAY);
      rchk(`IDX_STATUS, 32'h80);
      for (int i = 0; i < 4; i++) begin
        @(posedge ref_clk);
        b = eng_tx_bit;
        @(negedge ref_clk);
        chk(rx_serial, b);
      end
      for (int i = 0; i < 3; i++) begin
        rv = $random(seed);
        c = rv[7:0];
        d = rv[15:8];
        ev(1'b1, 1'b0, c);
        chk(rx_irq, 1'b1);
        rchk(`IDX_IFG, 32'h3);
        ev(1'b1, 1'b0, d);
        rchk(`IDX_STATUS, 32'ha0);
        rchk(`IDX_RXBUF, rxe(d, s[0]));
        rchk(`IDX_STATUS, 32'h80);
        rchk(`IDX_IFG, 32'h2);
        chk(irq, 1'b1);
        wr(`IDX_EVST, 32'hf);
        chk(irq, 1'b0);
      end
      rv = $random(seed);
      c = rv[7:0] | 8'h80;
      tx_wait <= s[0] ? 4'h0 : 4'hf;
      wr(`IDX_TXBUF, {24'h0, c});
      if (s == 0) begin
        rchk(`IDX_IFG, 32'h0);
        chk(tx_irq, 1'b0);
      end
      chk(tx_char, rxe(c, s[0]));
      while (!eng_busy) @(posedge ref_clk);
      rchk(`IDX_STATUS, 32'h81);
      while (eng_busy) @(posedge ref_clk);
      chk(sent_char, rxe(c, s[0]));
      rchk(`IDX_STATUS, 32'h80);
      rchk(`IDX_IFG, 32'h2);
      chk(tx_irq, 1'b1);
    end
    // Conflict only counts in 4-wire master operation
    for (int k = 0; k < 3; k++) begin
      cf = (k == 0) ? 32'hc : 32'h4 << (k - 1);
      wr(`IDX_CTRL, cf | 32'h1);
      wr(`IDX_CTRL, cf);
      chk({eng_master, eng_four_wire}, {cf[2], cf[3]});
      ev(1'b0, 1'b1, 8'h00);
      rchk(`IDX_STATUS, (k == 0) ? 32'hc0 : 32'h80);
      rdr(`IDX_RXBUF);
      rchk(`IDX_STATUS, 32'h80);
    end
    // Loopback off: receiver follows the synchronised pin
    wr(`IDX_CTRL, 32'h1);
    wr(`IDX_STATUS, 32'h0);
    wr(`IDX_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      somi_pin <= rv[0];
      repeat (4) @(posedge ref_clk);
      chk(rx_serial, somi_pin);
    end
    // Masked sources raise nothing
    wr(`IDX_IE, 32'h1);
    wr(`IDX_EVMSK, 32'h0);
    ev(1'b1, 1'b0, 8'h3c);
    chk(irq, 1'b0);
    chk(rx_irq, 1'b1);
    wr(`IDX_IE, 32'h2);
    chk(rx_irq, 1'b0);
    rchk(`IDX_IE, 32'h2);
    results();
  end

  // Watchdog
  initial begin
    #400000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
